// ### core/reset_sequencer.sv
// Reset pin sequencer, cause record, mode select and debug pin control
// Function
// - Any reset drives pin low 34 self ticks, releases, samples 38 later.
// - Internal resets expect the delayed pin sample to read one.
// - Decode each reset source and set its cause status bit.
// - Run from the roughly 8 MHz self clock throughout reset.
// - Self clock selectable as source for stop recovery.
// - Debug pin is mode select in reset, debug link afterwards.
// - Pin high at reset release enters normal mode.
// - Pin held low across reset release enters active debug mode.
// - Debug pin as port bit is output only.
// - Each debug link bit lasts 16 debug clock cycles.
// - Both parties drive brief high speedup pulses on debug pin.
// - Interrupt pin disabled after reset until software enables it.
// - After reset all 36 port pins are inputs without pulls.
// - Peripheral controls output buffer; direction bits choose read data.
// - Pull enable acts whenever pin is an input outside reset.
// - Upper keyboard pins pull down for rising or high sense.
// - Interrupt pin pulls down when enabled for rising edges.
// - Oscillator output pin is port bit with external clock input.
module reset_sequencer
  import rst_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic lvd_req,
  input wire logic cop_req,
  input wire logic ilop_req,
  input wire logic ilad_req,
  input wire logic stop_recover,
  input wire logic self_clk_stop_sel,
  output logic clock_src_self,
  output logic system_reset_n,
  output logic [CAUSE_W-1:0] reset_cause_status,
  output logic debug_mode_active,
  output logic debug_pin_is_link,
  input wire logic debug_mode_select_pin_in,
  output logic debug_mode_select_pin_out,
  output logic debug_mode_select_pin_oe,
  output logic debug_pin_pullup,
  input wire logic link_drive_low,
  input wire logic port_g_bit_zero_en,
  input wire logic port_g_bit_zero_data,
  output logic link_bit_tick,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] port_dir,
  input wire logic [NUM_PINS-1:0] port_out,
  input wire logic [NUM_PINS-1:0] pull_en,
  input wire logic [NUM_PINS-1:0] periph_own,
  input wire logic [NUM_PINS-1:0] periph_oe,
  input wire logic [NUM_PINS-1:0] periph_out,
  input wire logic [3:0] kbi_en,
  input wire logic [3:0] kbi_rise,
  input wire logic ext_osc_sel,
  input wire logic irq_sw_en,
  input wire logic irq_rise_sel,
  input wire logic irq_pull_en,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pull_up,
  output logic [NUM_PINS-1:0] pull_dn,
  output logic [NUM_PINS-1:0] port_read,
  output logic irq_pin_en,
  output logic irq_pull_up,
  output logic irq_pull_dn
);
  seq_ctrl_if ctl ();

  // ****************************************
  // Submodules
  // ****************************************
  self_clock_div u_clk (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ctl(ctl.clkgen)
  );

  pin_defaults u_pins (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ctl(ctl.pins),
    .pin_in(pin_in),
    .port_dir(port_dir),
    .port_out(port_out),
    .pull_en(pull_en),
    .periph_own(periph_own),
    .periph_oe(periph_oe),
    .periph_out(periph_out),
    .kbi_en(kbi_en),
    .kbi_rise(kbi_rise),
    .ext_osc_sel(ext_osc_sel),
    .irq_sw_en(irq_sw_en),
    .irq_rise_sel(irq_rise_sel),
    .irq_pull_en(irq_pull_en),
    .pin_oe(pin_oe),
    .pin_out(pin_out),
    .pull_up(pull_up),
    .pull_dn(pull_dn),
    .port_read(port_read),
    .irq_pin_en(irq_pin_en),
    .irq_pull_up(irq_pull_up),
    .irq_pull_dn(irq_pull_dn)
  );

  assign clock_src_self = ctl.clk_src_self;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic rp_s1_q, rp_s2_q, ms_s1_q, ms_s2_q;

  // Two stages for reset pin and mode select pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rp_s1_q <= 1'b1;
      rp_s2_q <= 1'b1;
      ms_s1_q <= 1'b1;
      ms_s2_q <= 1'b1;
    end else begin
      rp_s1_q <= reset_pin_in;
      rp_s2_q <= rp_s1_q;
      ms_s1_q <= debug_mode_select_pin_in;
      ms_s2_q <= ms_s1_q;
    end
  end

  // ****************************************
  // Reset sequence
  // ****************************************
  seq_state_t state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic [CAUSE_W-1:0] cause_q, cause_d;
  logic sysrst_n_q, sysrst_n_d;
  mode_t mode_q, mode_d;
  logic [CAUSE_W-1:0] new_cause;
  logic any_int;

  always_comb begin
    new_cause = '0;
    new_cause[CAUSE_LVD] = lvd_req;
    new_cause[CAUSE_COP] = cop_req;
    new_cause[CAUSE_ILOP] = ilop_req;
    new_cause[CAUSE_ILAD] = ilad_req;
    any_int = lvd_req | cop_req | ilop_req | ilad_req;
  end

  // State, tick count, cause record and mode latch
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cause_d = cause_q;
    sysrst_n_d = sysrst_n_q;
    mode_d = mode_q;
    case (state_q)
      ST_RUN: begin
        if (any_int) begin
          state_d = ST_DRIVE;
          cnt_d = 6'h00;
          cause_d = new_cause;
          sysrst_n_d = 1'b0;
        // external low level is a reset request
        end else if (!rp_s2_q) begin
          state_d = ST_DRIVE;
          cnt_d = 6'h00;
          cause_d = '0;
          cause_d[CAUSE_PIN] = 1'b1;
          sysrst_n_d = 1'b0;
        end
      end
      ST_DRIVE: begin
        // hold pin low for the drive interval
        if (ctl.self_tick) begin
          if (cnt_q == DRIVE_TICKS - 6'h01) begin
            state_d = ST_RELEASE;
            cnt_d = 6'h00;
          end else begin
            cnt_d = cnt_q + 6'h01;
          end
        end
      end
      ST_RELEASE: begin
        if (ctl.self_tick) begin
          if (cnt_q == SAMPLE_TICKS - 6'h01) begin
            if (rp_s2_q) begin
              state_d = ST_RUN;
              sysrst_n_d = 1'b1;
              mode_d = ms_s2_q ? MODE_NORMAL : MODE_DEBUG;
            end else begin
              state_d = ST_HOLD;
              cause_d[CAUSE_PIN] = 1'b1;
            end
            cnt_d = 6'h00;
          end else begin
            cnt_d = cnt_q + 6'h01;
          end
        end
      end
      ST_HOLD: begin
        // Pin still held low outside; wait for release
        if (rp_s2_q) begin
          state_d = ST_RUN;
          sysrst_n_d = 1'b1;
          mode_d = ms_s2_q ? MODE_NORMAL : MODE_DEBUG;
        end
      end
      default: begin
        state_d = ST_DRIVE;
        cnt_d = 6'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_DRIVE;
      cnt_q <= 6'h00;
      cause_q <= CAUSE_RST;
      sysrst_n_q <= 1'b0;
      mode_q <= MODE_NORMAL;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cause_q <= cause_d;
      sysrst_n_q <= sysrst_n_d;
      mode_q <= mode_d;
    end
  end

  assign ctl.in_reset = !sysrst_n_q;
  assign ctl.stop_recover = stop_recover;
  assign ctl.self_sel = self_clk_stop_sel;

  // ****************************************
  // Pin drivers
  // ****************************************
  logic rst_oe_d, ms_oe_d, ms_out_d, pu_d, link_d;
  logic spd_q, spd_d, lowp_q, lowp_d;
  logic [4:0] bit_q, bit_d;
  logic btick_d;

  // Reset pin, debug pin, speedup and bit timing
  always_comb begin
    rst_oe_d = (state_d == ST_DRIVE);
    link_d = sysrst_n_d & !port_g_bit_zero_en;
    lowp_d = link_d & link_drive_low;
    // one cycle high pulse after releasing low
    spd_d = link_d & lowp_q & !link_drive_low;
    ms_oe_d = 1'b0;
    ms_out_d = 1'b0;
    if (sysrst_n_d && port_g_bit_zero_en) begin
      ms_oe_d = 1'b1;
      ms_out_d = port_g_bit_zero_data;
    end else if (link_d) begin
      ms_oe_d = lowp_d | spd_d;
      ms_out_d = spd_d;
    end
    pu_d = !sysrst_n_d | link_d;
    // bit slot every 16 debug clocks
    bit_d = link_d ? 5'(bit_q + 5'h01) : 5'h00;
    if (bit_d == BIT_CLKS) begin
      bit_d = 5'h00;
    end
    btick_d = link_d && (bit_q == BIT_CLKS - 5'h01);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reset_pin_oe <= 1'b1;
      debug_mode_select_pin_oe <= 1'b0;
      debug_mode_select_pin_out <= 1'b0;
      debug_pin_pullup <= 1'b1;
      debug_pin_is_link <= 1'b0;
      spd_q <= 1'b0;
      lowp_q <= 1'b0;
      bit_q <= 5'h00;
      link_bit_tick <= 1'b0;
    end else begin
      reset_pin_oe <= rst_oe_d;
      debug_mode_select_pin_oe <= ms_oe_d;
      debug_mode_select_pin_out <= ms_out_d;
      debug_pin_pullup <= pu_d;
      debug_pin_is_link <= link_d;
      spd_q <= spd_d;
      lowp_q <= lowp_d;
      bit_q <= bit_d;
      link_bit_tick <= btick_d;
    end
  end

  assign reset_pin_out = 1'b0;
  assign system_reset_n = sysrst_n_q;
  assign reset_cause_status = cause_q;
  assign debug_mode_active = (mode_q == MODE_DEBUG);

  // ****************************************
  // Assertions
  // ****************************************
  property p_drive_len;
    @(posedge ref_clk) disable iff (!nrst)
    (state_q == ST_DRIVE && state_d == ST_RELEASE) |-> ctl.self_tick && cnt_q == 6'h21;
  endproperty
  a_drive_len: assert property (p_drive_len) else $error("drive interval wrong");
  property p_sample_len;
    @(posedge ref_clk) disable iff (!nrst)
    (state_q == ST_RELEASE && state_d != ST_RELEASE) |-> cnt_q == 6'h25 ##1 !reset_pin_oe;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample interval wrong");
  property p_int_hold;
    @(posedge ref_clk) disable iff (!nrst)
    (state_q == ST_RELEASE && state_d != ST_RELEASE && !rp_s2_q) |=> !system_reset_n;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("low sample released reset");
  property p_cause_lvd;
    @(posedge ref_clk) disable iff (!nrst)
    (state_q == ST_RUN && lvd_req) |=> reset_cause_status[CAUSE_LVD] && !system_reset_n;
  endproperty
  a_cause_lvd: assert property (p_cause_lvd) else $error("cause not recorded");
  property p_self_src;
    @(posedge ref_clk) disable iff (!nrst)
    !system_reset_n |=> clock_src_self;
  endproperty
  a_self_src: assert property (p_self_src) else $error("self clock not used");
  property p_pin_req;
    @(posedge ref_clk) disable iff (!nrst)
    (state_q == ST_RUN && !any_int && !rp_s2_q) |=> reset_pin_oe && reset_cause_status[CAUSE_PIN];
  endproperty
  a_pin_req: assert property (p_pin_req) else $error("pin request ignored");
  property p_mode;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(system_reset_n) |-> debug_mode_active == !$past(ms_s2_q);
  endproperty
  a_mode: assert property (p_mode) else $error("mode latch wrong");
  property p_gpio_out;
    @(posedge ref_clk) disable iff (!nrst)
    (sysrst_n_d && port_g_bit_zero_en) |=> debug_mode_select_pin_oe;
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("port bit not output");
  property p_bit_time;
    @(posedge ref_clk) disable iff (!nrst)
    (link_bit_tick && link_d) ##1 link_d [*8] ##1 link_d [*7] |=> link_bit_tick;
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("bit time not 16");
  property p_speedup;
    @(posedge ref_clk) disable iff (!nrst)
    (link_d && lowp_q && !link_drive_low) |=> debug_mode_select_pin_out && debug_mode_select_pin_oe;
  endproperty
  a_speedup: assert property (p_speedup) else $error("no speedup pulse");
  property p_irq_off;
    @(posedge ref_clk) disable iff (!nrst)
    !system_reset_n |=> !irq_pin_en;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq enabled in reset");
  c_int_reset: cover property (@(posedge ref_clk) state_q == ST_RUN && cop_req);
  c_hold: cover property (@(posedge ref_clk) state_q == ST_HOLD);
  c_debug: cover property (@(posedge ref_clk) $rose(debug_mode_active));
  c_speed: cover property (@(posedge ref_clk) spd_q);
endmodule : reset_sequencer

// ### core/rst_seq_pkg.sv
// Constants and types shared by the reset and pin default logic
package rst_seq_pkg;
  // Self clock: 8 of every 10 reference cycles carry a tick
  localparam logic [3:0] SELF_NUM = 4'h8;
  localparam logic [3:0] SELF_DEN = 4'ha;
  // Reset pin drive and sample spacing, in self clock ticks
  localparam logic [5:0] DRIVE_TICKS = 6'h22;
  localparam logic [5:0] SAMPLE_TICKS = 6'h26;
  // Debug link bit time in debug clock cycles
  localparam logic [4:0] BIT_CLKS = 5'h10;
  // Shared port pins
  localparam int NUM_PINS = 36;
  localparam int KBI_UP_BASE = 4;
  localparam int OSC_OUT_PIN = 34;
  // Cause bit positions and reset value
  localparam int CAUSE_W = 6;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_COP = 2;
  localparam int CAUSE_ILOP = 3;
  localparam int CAUSE_ILAD = 4;
  localparam int CAUSE_LVD = 5;
  localparam logic [5:0] CAUSE_RST = 6'h01;
  typedef enum logic {MODE_NORMAL, MODE_DEBUG} mode_t;
  typedef enum logic [1:0] {ST_RUN, ST_DRIVE, ST_RELEASE, ST_HOLD} seq_state_t;
endpackage : rst_seq_pkg

// ### core/seq_ctrl_if.sv
// Signals between the sequencer, self clock divider and pin defaults
interface seq_ctrl_if;
  logic in_reset;
  logic stop_recover;
  logic self_sel;
  logic self_tick;
  logic clk_src_self;
  modport seq (output in_reset, stop_recover, self_sel, input self_tick, clk_src_self);
  modport clkgen (input in_reset, stop_recover, self_sel, output self_tick, clk_src_self);
  modport pins (input in_reset);
endinterface : seq_ctrl_if

// ### core/self_clock_div.sv
// Self clock tick generator and clock source select
module self_clock_div
  import rst_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  seq_ctrl_if.clkgen ctl
);
  logic [3:0] acc_q, acc_d;
  logic tick_q, tick_d;
  logic src_q, src_d;

  // Fractional accumulator, self clock used in reset, or in stop recovery when self_sel is set
  always_comb begin
    logic [4:0] sum;
    sum = {1'b0, acc_q} + {1'b0, SELF_NUM};
    tick_d = (sum >= {1'b0, SELF_DEN});
    acc_d = tick_d ? 4'(sum - {1'b0, SELF_DEN}) : sum[3:0];
    src_d = ctl.in_reset | (ctl.stop_recover & ctl.self_sel);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= 4'h0;
      tick_q <= 1'b0;
      src_q <= 1'b1;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
      src_q <= src_d;
    end
  end

  assign ctl.self_tick = tick_q;
  assign ctl.clk_src_self = src_q;
endmodule : self_clock_div

// ### core/pin_defaults.sv
// Shared port pin direction, pull control and read path
module pin_defaults
  import rst_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  seq_ctrl_if.pins ctl,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] port_dir,
  input wire logic [NUM_PINS-1:0] port_out,
  input wire logic [NUM_PINS-1:0] pull_en,
  input wire logic [NUM_PINS-1:0] periph_own,
  input wire logic [NUM_PINS-1:0] periph_oe,
  input wire logic [NUM_PINS-1:0] periph_out,
  input wire logic [3:0] kbi_en,
  input wire logic [3:0] kbi_rise,
  input wire logic ext_osc_sel,
  input wire logic irq_sw_en,
  input wire logic irq_rise_sel,
  input wire logic irq_pull_en,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pull_up,
  output logic [NUM_PINS-1:0] pull_dn,
  output logic [NUM_PINS-1:0] port_read,
  output logic irq_pin_en,
  output logic irq_pull_up,
  output logic irq_pull_dn
);
  logic [NUM_PINS-1:0] s1_q, s2_q;
  logic [NUM_PINS-1:0] oe_d, out_d, up_d, dn_d, rd_d;
  logic irq_en_d, irq_up_d, irq_dn_d;

  // Per pin ownership, pull polarity and read source
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    logic own_oe, drv, down;
    assign own_oe = periph_own[i] ? periph_oe[i] : port_dir[i];
    // oscillator output pin usable only with external clock
    assign drv = own_oe & ((i != OSC_OUT_PIN) | ext_osc_sel);
    // upper keyboard pins pull down for rising sense
    if (i >= KBI_UP_BASE && i < KBI_UP_BASE + 4) begin : g_kbi
      assign down = kbi_en[i-KBI_UP_BASE] & kbi_rise[i-KBI_UP_BASE];
    end else begin : g_plain
      assign down = 1'b0;
    end
    // inputs with no pulls during reset
    assign oe_d[i] = !ctl.in_reset & drv;
    assign out_d[i] = periph_own[i] ? periph_out[i] : port_out[i];
    // pull acts whenever pin is an input outside reset
    assign up_d[i] = !ctl.in_reset & !drv & pull_en[i] & !down;
    assign dn_d[i] = !ctl.in_reset & !drv & pull_en[i] & down;
    // direction bit picks latch or pin
    assign rd_d[i] = port_dir[i] ? port_out[i] : s2_q[i];
  end

  // interrupt pin off in reset, pull polarity
  always_comb begin
    irq_en_d = !ctl.in_reset & irq_sw_en;
    irq_up_d = irq_en_d & irq_pull_en & !irq_rise_sel;
    irq_dn_d = irq_en_d & irq_pull_en & irq_rise_sel;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      pin_oe <= '0;
      pin_out <= '0;
      pull_up <= '0;
      pull_dn <= '0;
      port_read <= '0;
      irq_pin_en <= 1'b0;
      irq_pull_up <= 1'b0;
      irq_pull_dn <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      pin_oe <= oe_d;
      pin_out <= out_d;
      pull_up <= up_d;
      pull_dn <= dn_d;
      port_read <= rd_d;
      irq_pin_en <= irq_en_d;
      irq_pull_up <= irq_up_d;
      irq_pull_dn <= irq_dn_d;
    end
  end
endmodule : pin_defaults

// ### test/ext_party.sv
// Reset switch and debug pod model on the far side of the pins
module ext_party (
  input wire logic ref_clk,
  input wire logic rst_oe,
  input wire logic dbg_oe,
  input wire logic dbg_out,
  input wire logic hold_rst,
  input wire logic hold_ms,
  output logic rst_lvl,
  output logic dbg_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Wire resolution
  // ****************
  logic ms_q;
  // Pod hold history for its speedup pulse
  always @(posedge ref_clk) begin
    ms_q <= hold_ms;
  end
  // switch to ground
  // Pulled up unless device or switch pulls low
  assign rst_lvl = ~(rst_oe | hold_rst);
  // pod hold and speedup
  // Device drive wins, then pod low, pod speedup high, pull-up
  always_comb begin
    if (dbg_oe) begin
      dbg_lvl = dbg_out;
    end else if (hold_ms) begin
      dbg_lvl = 1'b0;
    end else if (ms_q) begin
      dbg_lvl = 1'b1;
    end else begin
      dbg_lvl = 1'b1;
    end
  end
endmodule : ext_party

// ### test/tb_reset_sequencer.sv
// Self-checking bench for the reset sequencer and pin defaults
module tb_reset_sequencer
  import rst_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Bench signals
  // ****************
  logic ref_clk, nrst, reset_pin_in, reset_pin_out, reset_pin_oe;
  logic lvd_req, cop_req, ilop_req, ilad_req, stop_recover, self_clk_stop_sel;
  logic clock_src_self, system_reset_n, debug_mode_active, debug_pin_is_link;
  logic debug_mode_select_pin_in, debug_mode_select_pin_out, debug_mode_select_pin_oe;
  logic debug_pin_pullup, link_drive_low, port_g_bit_zero_en, port_g_bit_zero_data;
  logic link_bit_tick, ext_osc_sel, irq_sw_en, irq_rise_sel, irq_pull_en;
  logic irq_pin_en, irq_pull_up, irq_pull_dn, hold_rst, hold_ms;
  logic [CAUSE_W-1:0] reset_cause_status;
  logic [3:0] kbi_en, kbi_rise;
  logic [NUM_PINS-1:0] pin_in, port_dir, port_out, pull_en, periph_own, periph_oe;
  logic [NUM_PINS-1:0] periph_out, pin_oe, pin_out, pull_up, pull_dn, port_read;
  int num_errors = 0;
  int n_checks = 0;
  int src_q[$] = '{CAUSE_LVD, CAUSE_COP, CAUSE_ILOP, CAUSE_ILAD};
  int n;

  reset_sequencer dut_u (.ref_clk, .nrst, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
    .lvd_req, .cop_req, .ilop_req, .ilad_req, .stop_recover, .self_clk_stop_sel,
    .clock_src_self, .system_reset_n, .reset_cause_status, .debug_mode_active,
    .debug_pin_is_link, .debug_mode_select_pin_in, .debug_mode_select_pin_out,
    .debug_mode_select_pin_oe, .debug_pin_pullup, .link_drive_low, .port_g_bit_zero_en,
    .port_g_bit_zero_data, .link_bit_tick, .pin_in, .port_dir, .port_out, .pull_en,
    .periph_own, .periph_oe, .periph_out, .kbi_en, .kbi_rise, .ext_osc_sel, .irq_sw_en,
    .irq_rise_sel, .irq_pull_en, .pin_oe, .pin_out, .pull_up, .pull_dn, .port_read,
    .irq_pin_en, .irq_pull_up, .irq_pull_dn);

  ext_party pod_u (.ref_clk, .rst_oe(reset_pin_oe), .dbg_oe(debug_mode_select_pin_oe),
    .dbg_out(debug_mode_select_pin_out), .hold_rst, .hold_ms, .rst_lvl(reset_pin_in),
    .dbg_lvl(debug_mode_select_pin_in));

  // Clock of 100 ns period
  always #50 ref_clk = ~ref_clk;

  task automatic chk(input logic [NUM_PINS-1:0] got, input logic [NUM_PINS-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_win(input int c, input int lo, input int hi);
    n_checks++;
    if (c < lo || c > hi) begin
      num_errors++;
      $display("[ERR] t=%0t cycles=%h window=%h..%h", $time, c, lo, hi);
    end
  endtask : chk_win

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick

  function automatic logic sig(input int k);
    return k == 0 ? reset_pin_oe : (k == 1 ? system_reset_n : link_bit_tick);
  endfunction : sig

  // Wait under a bound until a watched output reaches a level
  task automatic wait_lvl(input int k, input logic v);
    n = 0;
    while (sig(k) !== v && n < 400) begin
      tick(1);
      n++;
    end
    if (sig(k) !== v) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, sig(k), v);
    end
  endtask : wait_lvl

  // One reset sequence: drive span, release span, cause and debug pin state
  task automatic run_seq(input logic [5:0] cause, input logic timed);
    tick(1);
    wait_lvl(0, 1'b1);
    chk(clock_src_self, 1'b1);
    chk(system_reset_n, 1'b0);
    chk(debug_pin_is_link, 1'b0);
    chk(debug_mode_select_pin_oe, 1'b0);
    chk(debug_pin_pullup, 1'b1);
    chk(reset_pin_out, 1'b0);
    wait_lvl(0, 1'b0);
    if (timed) chk_win(n, DRIVE_TICKS * SELF_DEN / SELF_NUM - 1, 45);
    wait_lvl(1, 1'b1);
    if (timed) chk_win(n, SAMPLE_TICKS * SELF_DEN / SELF_NUM - 1, 51);
    chk(reset_cause_status, cause);
    chk(debug_pin_is_link, 1'b1);
    chk(debug_pin_pullup, 1'b1);
  endtask : run_seq

  // Random pin settings against the pin model
  task automatic pin_round;
    logic [NUM_PINS-1:0] oe, ot, rd, pu, pd;
    logic dn;
    @(posedge ref_clk);
    pin_in <= NUM_PINS'({$urandom(), $urandom()});
    port_dir <= NUM_PINS'({$urandom(), $urandom()});
    port_out <= NUM_PINS'({$urandom(), $urandom()});
    pull_en <= NUM_PINS'({$urandom(), $urandom()});
    periph_own <= NUM_PINS'({$urandom(), $urandom()});
    periph_oe <= NUM_PINS'({$urandom(), $urandom()});
    periph_out <= NUM_PINS'({$urandom(), $urandom()});
    {ext_osc_sel, irq_sw_en, irq_rise_sel, irq_pull_en, kbi_en, kbi_rise} <= 12'($urandom());
    tick(4);
    for (int i = 0; i < NUM_PINS; i++) begin
      oe[i] = (periph_own[i] ? periph_oe[i] : port_dir[i]) & (i != OSC_OUT_PIN || ext_osc_sel);
      ot[i] = periph_own[i] ? periph_out[i] : port_out[i];
      rd[i] = port_dir[i] ? port_out[i] : pin_in[i];
      dn = i >= KBI_UP_BASE && i < KBI_UP_BASE + 4 && kbi_en[(i - KBI_UP_BASE) & 3] &&
        kbi_rise[(i - KBI_UP_BASE) & 3];
      pu[i] = pull_en[i] & ~oe[i] & ~dn;
      pd[i] = pull_en[i] & ~oe[i] & dn;
    end
    chk(pin_oe, oe);
    chk(pin_out, ot);
    chk(pin_oe[OSC_OUT_PIN] & ~ext_osc_sel, 1'b0);
    chk(port_read, rd);
    chk(pull_up, pu);
    chk(pull_dn, pd);
    chk(irq_pin_en, irq_sw_en);
    chk(irq_pull_up, irq_sw_en & irq_pull_en & ~irq_rise_sel);
    chk(irq_pull_dn, irq_sw_en & irq_pull_en & irq_rise_sel);
  endtask : pin_round

  task automatic end_sim;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // Watchdog against a hung sequence
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end

  // ****************
  // Test sequence
  // ****************
  initial begin
    {ref_clk, nrst, lvd_req, cop_req, ilop_req, ilad_req, stop_recover} = '0;
    {self_clk_stop_sel, link_drive_low, port_g_bit_zero_en, port_g_bit_zero_data} = '0;
    {ext_osc_sel, irq_sw_en, irq_rise_sel, irq_pull_en, kbi_en, kbi_rise} = '0;
    {pin_in, port_out, periph_own, periph_oe, periph_out, hold_rst, hold_ms} = '0;
    port_dir = '1;
    pull_en = '1;
    void'($urandom(32'h2a23));
    tick(2);
    chk(pin_oe | pull_up | pull_dn, '0);
    chk(irq_pin_en, 1'b0);
    @(posedge ref_clk);
    nrst <= 1'b1;
    port_dir <= '0;
    pull_en <= '0;
    run_seq(CAUSE_RST, 1'b1);
    chk(debug_mode_active, 1'b0);
    chk(pin_oe | pull_up | pull_dn, '0);
    $display("power-on sequence done");
    foreach (src_q[i]) begin
      @(posedge ref_clk);
      {lvd_req, cop_req, ilop_req, ilad_req} <= 4'h8 >> i;
      @(posedge ref_clk);
      {lvd_req, cop_req, ilop_req, ilad_req} <= 4'h0;
      run_seq(6'h01 << src_q[i], 1'b1);
    end
    $display("internal sources done");
    @(posedge ref_clk);
    hold_rst <= 1'b1;
    hold_ms <= 1'b1;
    tick(12);
    @(posedge ref_clk);
    hold_rst <= 1'b0;
    run_seq(6'h01 << CAUSE_PIN, 1'b0);
    chk(debug_mode_active, 1'b1);
    @(posedge ref_clk);
    hold_ms <= 1'b0;
    cop_req <= 1'b1;
    @(posedge ref_clk);
    cop_req <= 1'b0;
    hold_rst <= 1'b1;
    tick(150);
    chk(system_reset_n, 1'b0);
    chk(reset_cause_status, 6'h06);
    @(posedge ref_clk);
    hold_rst <= 1'b0;
    wait_lvl(1, 1'b1);
    chk_win(n, 1, 30);
    chk(debug_mode_active, 1'b0);
    $display("pin reset and low sample done");
    wait_lvl(2, 1'b1);
    tick(1);
    wait_lvl(2, 1'b1);
    chk_win(n + 1, BIT_CLKS, BIT_CLKS);
    @(posedge ref_clk);
    link_drive_low <= 1'b1;
    @(posedge ref_clk);
    link_drive_low <= 1'b0;
    #1;
    chk({debug_mode_select_pin_oe, debug_mode_select_pin_out}, 2'h2);
    tick(1);
    chk({debug_mode_select_pin_oe, debug_mode_select_pin_out}, 2'h3);
    tick(1);
    chk(debug_mode_select_pin_oe, 1'b0);
    @(posedge ref_clk);
    stop_recover <= 1'b1;
    self_clk_stop_sel <= 1'b1;
    tick(3);
    chk(clock_src_self, 1'b1);
    @(posedge ref_clk);
    self_clk_stop_sel <= 1'b0;
    tick(3);
    chk(clock_src_self, 1'b0);
    @(posedge ref_clk);
    stop_recover <= 1'b0;
    port_g_bit_zero_en <= 1'b1;
    port_g_bit_zero_data <= 1'($urandom());
    tick(3);
    chk({debug_mode_select_pin_oe, debug_mode_select_pin_out},
      {1'b1, port_g_bit_zero_data});
    $display("debug pin and clock source done");
    repeat (24) pin_round();
    $display("pin defaults done");
    end_sim();
  end
endmodule : tb_reset_sequencer
